// ---- logic/temp_link_slave.sv ----
`timescale 1ns/1ps
module temp_link_slave #(
  parameter int CONV_US    = thermo_link_pkg::CONV_TIME_US,
  parameter int US_DIV     = thermo_link_pkg::US_CYCLES,
  parameter int SAMPLE_W   = 12,
  parameter int FIFO_DEPTH = 8
)(
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                dq_i,
  output logic                     dq_o,
  output logic                     dq_oe,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  input  wire logic                sample_valid,
  output logic                     sample_ready,
  output logic                     conv_busy,
  output logic [15:0]              temp_word
);
  import thermo_link_pkg::*;

  if (SAMPLE_W < 9 || SAMPLE_W > 16 || CONV_US < 2 || CONV_US >= (1 << 20)
      || US_DIV < 2 || US_DIV > 256)
  begin : g_chk
    $error("temp_link_slave parameter out of range");
  end

  link_state_e         state_r;
  logic                dq_meta_r;
  logic                dq_sync_r;
  logic                dq_prev_r;
  logic [7:0]          div_cnt_r;
  logic [9:0]          low_us_r;
  logic [9:0]          slot_us_r;
  logic                slot_act_r;
  logic [7:0]          st_us_r;
  logic [2:0]          bit_cnt_r;
  logic [3:0]          byte_idx_r;
  logic [7:0]          shift_r;
  logic                tx_low_r;
  logic                conv_busy_r;
  logic [19:0]         conv_us_r;
  logic [7:0]          sp_r [SP_BYTES];
  logic [7:0]          nv_ua_r;
  logic [7:0]          nv_ub_r;
  logic [15:0]         ack_gap_r;
  logic [SAMPLE_W-1:0] fifo_data;
  logic                fifo_valid;
  logic                fall;
  logic                rise;
  logic                us_tick;
  logic                reset_seen;
  logic                bit_evt;
  logic                byte_done;
  logic                ack_start;
  logic                ack_end;
  logic                conv_start;
  logic                store_evt;
  logic                tx_bit;
  logic [7:0]          rx_byte;
  logic [15:0]         new_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] to_word(input logic [SAMPLE_W-1:0] v);
    logic signed [SAMPLE_W-1:0] c;
    c = $signed(v);
    if (c < TEMP_MIN_HALF)
      c = SAMPLE_W'(TEMP_MIN_HALF);
    if (c > TEMP_MAX_HALF)
      c = SAMPLE_W'(TEMP_MAX_HALF);
    to_word = {(c < 0) ? SIGN_NEG : SIGN_POS, c[7:0]};
  endfunction : to_word

  function automatic logic in_rx(input link_state_e s);
    in_rx = (s == ST_ROM) || (s == ST_FUNC) || (s == ST_WR_DATA);
  endfunction : in_rx

  // ----------------------------------------------------------------
  // line input and time base
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dq_meta_r <= 1'b1;
      dq_sync_r <= 1'b1;
      dq_prev_r <= 1'b1;
    end
    else
    begin
      dq_meta_r <= dq_i;
      dq_sync_r <= dq_meta_r;
      dq_prev_r <= dq_sync_r;
    end
  end

  assign fall    = dq_prev_r && !dq_sync_r;
  assign rise    = !dq_prev_r && dq_sync_r;
  assign us_tick = div_cnt_r == 8'(US_DIV - 1);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      div_cnt_r <= '0;
    else if (us_tick)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 8'h01;
  end

  // low time of the line, for reset detection
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      low_us_r <= '0;
    else if (fall)
      low_us_r <= '0;
    else if (us_tick && !dq_sync_r && low_us_r != 10'h3FF)
      low_us_r <= low_us_r + 10'h001;
  end

  assign reset_seen = rise && (low_us_r >= 10'(RESET_LOW_MIN_US));

  // ----------------------------------------------------------------
  // slot timing, all opened by the master's falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_us_r  <= '0;
      slot_act_r <= 1'b0;
    end
    else if (fall && state_r != ST_ACK)
    begin
      slot_us_r  <= '0;
      slot_act_r <= 1'b1;
    end
    else
    begin
      if (us_tick && slot_us_r != 10'h3FF)
        slot_us_r <= slot_us_r + 10'h001;
      if (bit_evt || reset_seen)
        slot_act_r <= 1'b0;
    end
  end

  assign bit_evt   = slot_act_r && us_tick
                     && slot_us_r == 10'(SAMPLE_US - 1);
  assign byte_done = bit_evt && bit_cnt_r == 3'h7;
  assign rx_byte   = {dq_sync_r, shift_r[7:1]};

  // ----------------------------------------------------------------
  // state timer for the acknowledge
  // ----------------------------------------------------------------
  assign ack_start = state_r == ST_ACK_WAIT && us_tick
                     && st_us_r == 8'(ACK_DELAY_US - 1);
  assign ack_end   = state_r == ST_ACK && us_tick
                     && st_us_r == 8'(ACK_LEN_US - 1);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_us_r <= '0;
    else if (reset_seen || ack_start)
      st_us_r <= '0;
    else if (us_tick && st_us_r != 8'hFF)
      st_us_r <= st_us_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= ST_IDLE;
    else if (reset_seen)
      state_r <= ST_ACK_WAIT;
    else
    begin
      case (state_r)
        ST_ACK_WAIT:
          if (ack_start)
            state_r <= ST_ACK;
        ST_ACK:
          if (ack_end)
            state_r <= ST_ROM;
        ST_ROM:
          if (byte_done)
            state_r <= (rx_byte == CMD_SKIP) ? ST_FUNC : ST_IDLE;
        ST_FUNC:
          if (byte_done)
          begin
            case (rx_byte)
              CMD_CONVERT:  state_r <= ST_CONV;
              CMD_READ_SP:  state_r <= ST_RD_DATA;
              CMD_WRITE_SP: state_r <= ST_WR_DATA;
              default:      state_r <= ST_IDLE;
            endcase
          end
        ST_WR_DATA:
          if (byte_done && byte_idx_r == SP_IDX_UB)
            state_r <= ST_IDLE;
        ST_RD_DATA:
          if (byte_done && byte_idx_r == SP_IDX_END)
            state_r <= ST_IDLE;
        ST_IDLE, ST_CONV:
          state_r <= state_r;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit and byte counting, LSB first both ways
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      bit_cnt_r <= '0;
    else if (reset_seen)
      bit_cnt_r <= '0;
    else if (bit_evt && (in_rx(state_r) || state_r == ST_RD_DATA))
      bit_cnt_r <= bit_cnt_r + 3'h1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      shift_r <= '0;
    else if (bit_evt && in_rx(state_r))
      shift_r <= rx_byte;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      byte_idx_r <= '0;
    else if (byte_done && state_r == ST_FUNC)
      byte_idx_r <= (rx_byte == CMD_WRITE_SP) ? SP_IDX_UA : SP_IDX_TLO;
    else if (byte_done
             && (state_r == ST_WR_DATA || state_r == ST_RD_DATA))
      byte_idx_r <= byte_idx_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // line drive: acknowledge and zero bits only
  // ----------------------------------------------------------------
  always_comb
  begin
    case (state_r)
      ST_RD_DATA: tx_bit = sp_r[byte_idx_r][bit_cnt_r];
      ST_CONV:    tx_bit = !conv_busy_r;
      default:    tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      tx_low_r <= 1'b0;
    else if (bit_evt || reset_seen)
      tx_low_r <= 1'b0;
    else if (fall && !tx_bit)
      tx_low_r <= 1'b1;
  end

  assign dq_o  = 1'b0;
  assign dq_oe = (state_r == ST_ACK) || tx_low_r;

  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  assign conv_start = state_r == ST_FUNC && byte_done
                      && rx_byte == CMD_CONVERT;
  assign store_evt  = conv_busy_r && fifo_valid;
  assign new_word   = to_word(fifo_data);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conv_busy_r <= 1'b0;
      conv_us_r   <= '0;
    end
    else if (conv_start && !conv_busy_r)
    begin
      conv_busy_r <= 1'b1;
      conv_us_r   <= '0;
    end
    else if (conv_busy_r)
    begin
      if (store_evt || (us_tick && conv_us_r == 20'(CONV_US - 1)))
        conv_busy_r <= 1'b0;
      else if (us_tick)
        conv_us_r <= conv_us_r + 20'h00001;
    end
  end

  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (conv_busy_r)
  );

  // ----------------------------------------------------------------
  // scratchpad and nonvolatile copy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < SP_BYTES; i++)
        sp_r[i] <= SP_RSV_VAL;
      sp_r[SP_IDX_TLO] <= TLO_RST;
      sp_r[SP_IDX_THI] <= SIGN_POS;
      sp_r[SP_IDX_UA]  <= NV_UA_RST;
      sp_r[SP_IDX_UB]  <= NV_UB_RST;
    end
    else if (store_evt)
    begin
      sp_r[SP_IDX_TLO] <= new_word[7:0];
      sp_r[SP_IDX_THI] <= new_word[15:8];
    end
    else if (byte_done && state_r == ST_WR_DATA)
      sp_r[byte_idx_r] <= rx_byte;
    else if (byte_done && state_r == ST_FUNC && rx_byte == CMD_RECALL)
    begin
      sp_r[SP_IDX_UA] <= nv_ua_r;
      sp_r[SP_IDX_UB] <= nv_ub_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nv_ua_r <= NV_UA_RST;
      nv_ub_r <= NV_UB_RST;
    end
    else if (byte_done && state_r == ST_FUNC && rx_byte == CMD_COPY_SP)
    begin
      nv_ua_r <= sp_r[SP_IDX_UA];
      nv_ub_r <= sp_r[SP_IDX_UB];
    end
  end

  assign conv_busy = conv_busy_r;
  assign temp_word = {sp_r[SP_IDX_THI], sp_r[SP_IDX_TLO]};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int ACK_LO_CYC = ACK_DELAY_MIN_US * US_DIV;
  localparam int ACK_HI_CYC = ACK_DELAY_MAX_US * US_DIV;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_gap_r <= '0;
    else if (reset_seen)
      ack_gap_r <= '0;
    else if (state_r == ST_ACK_WAIT && ack_gap_r != 16'hFFFF)
      ack_gap_r <= ack_gap_r + 16'h0001;
  end

  sequence s_reset_end;
    reset_seen;
  endsequence

  sequence s_ack_pending;
    state_r == ST_ACK_WAIT && !dq_oe;
  endsequence

  sequence s_skip_taken;
    state_r == ST_ROM && byte_done && rx_byte == CMD_SKIP;
  endsequence

  AST_RESET_ACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_reset_end |=> s_ack_pending [*8])
    else $error("acknowledge not pending after reset");

  AST_ACK_WINDOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == ST_ACK) |->
      (ack_gap_r >= ACK_LO_CYC && ack_gap_r <= ACK_HI_CYC))
    else $error("acknowledge outside its window");

  AST_NO_SELF_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(dq_oe) |-> (state_r == ST_ACK || !dq_sync_r))
    else $error("line driven without master slot");

  AST_ZERO_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(tx_low_r) |-> (tx_low_r && dq_oe) [*8])
    else $error("zero bit released too early");

  AST_SKIP_CMD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_skip_taken |=> state_r == ST_FUNC)
    else $error("bypass byte not accepted");

  AST_SIGN_BYTE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sp_r[SP_IDX_THI] == SIGN_POS || sp_r[SP_IDX_THI] == SIGN_NEG)
    else $error("temperature sign byte invalid");

  AST_LOW_RANGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sp_r[SP_IDX_THI] == SIGN_NEG) ? (sp_r[SP_IDX_TLO] >= LO_NEG_LIMIT)
                                   : (sp_r[SP_IDX_TLO] <= LO_POS_LIMIT))
    else $error("temperature low byte out of range");

  AST_STORE_ORDER: assert property (@(posedge clk_sys) disable iff (sys_rst)
    store_evt |=> {sp_r[SP_IDX_THI], sp_r[SP_IDX_TLO]} == $past(new_word)
                  && !conv_busy_r)
    else $error("converted word stored wrongly");

  AST_CONV_BOUND: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_busy_r |-> conv_us_r < 20'(CONV_US))
    else $error("conversion exceeded its time");

  AST_LSB_FIRST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fall && state_r == ST_RD_DATA && bit_cnt_r == 3'h0)
      |=> tx_low_r == !sp_r[byte_idx_r][0])
    else $error("read data not least bit first");

endmodule : temp_link_slave

// ---- logic/thermo_link_pkg.sv ----
package thermo_link_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // line timing in microseconds
  // ----------------------------------------------------------------
  localparam int RESET_LOW_MIN_US = 480;
  localparam int ACK_DELAY_MIN_US = 15;
  localparam int ACK_DELAY_MAX_US = 60;
  localparam int ACK_DELAY_US     = 30;
  localparam int ACK_LEN_US       = 120;
  localparam int SLOT_MIN_US      = 60;
  localparam int RECOVERY_MIN_US  = 1;
  localparam int RD_VALID_US      = 15;
  localparam int SAMPLE_US        = 30;
  localparam int CONV_TIME_US     = 1000000;

  // derived cycle counts for the acknowledge window
  localparam int ACK_MIN_CYC = ACK_DELAY_MIN_US * US_CYCLES;
  localparam int ACK_MAX_CYC = ACK_DELAY_MAX_US * US_CYCLES;

  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SKIP     = 8'hCC;
  localparam logic [7:0] CMD_CONVERT  = 8'h44;
  localparam logic [7:0] CMD_READ_SP  = 8'hBE;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
  localparam logic [7:0] CMD_COPY_SP  = 8'h48;
  localparam logic [7:0] CMD_RECALL   = 8'hB8;

  // ----------------------------------------------------------------
  // scratchpad layout and reset values
  // ----------------------------------------------------------------
  localparam int         SP_BYTES   = 9;
  localparam logic [3:0] SP_IDX_TLO = 4'h0;
  localparam logic [3:0] SP_IDX_THI = 4'h1;
  localparam logic [3:0] SP_IDX_UA  = 4'h2;
  localparam logic [3:0] SP_IDX_UB  = 4'h3;
  localparam logic [3:0] SP_IDX_END = 4'h8;
  localparam logic [7:0] SP_RSV_VAL = 8'hFF;
  localparam logic [7:0] TLO_RST    = 8'h00;
  localparam logic [7:0] NV_UA_RST  = 8'h00;
  localparam logic [7:0] NV_UB_RST  = 8'h00;

  // ----------------------------------------------------------------
  // temperature word format, half degree steps
  // ----------------------------------------------------------------
  localparam int         TEMP_MIN_HALF = -110;
  localparam int         TEMP_MAX_HALF = 250;
  localparam logic [7:0] SIGN_NEG      = 8'hFF;
  localparam logic [7:0] SIGN_POS      = 8'h00;
  localparam logic [7:0] LO_POS_LIMIT  = 8'hFA;
  localparam logic [7:0] LO_NEG_LIMIT  = 8'h92;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ACK_WAIT = 8'h02,
    ST_ACK      = 8'h04,
    ST_ROM      = 8'h08,
    ST_FUNC     = 8'h10,
    ST_WR_DATA  = 8'h20,
    ST_RD_DATA  = 8'h40,
    ST_CONV     = 8'h80
  } link_state_e;

endpackage : thermo_link_pkg

// ---- logic/sample_fifo.sv ----
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
)(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("sample_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      wr_ptr_r <= '0;
    else if (push)
      wr_ptr_r <= wr_ptr_r + 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rd_ptr_r <= '0;
    else if (pop)
      rd_ptr_r <= rd_ptr_r + 1'b1;
  end

endmodule : sample_fifo

// ---- tb/line_master.sv ----
`timescale 1ns/1ps
module line_master #(
  parameter int US_DIV = thermo_link_pkg::US_CYCLES
)(
  input  wire logic clk_sys,
  input  wire logic dq_line,
  output logic      drive_low
);
  import thermo_link_pkg::*;

  // --------------------------------------------------------------
  // bus master: only party that opens frames and slots
  // --------------------------------------------------------------
  initial drive_low = 1'b0;

  task automatic hold(input int us);
    repeat (us * US_DIV) @(posedge clk_sys);
  endtask : hold

  // reset low pulse, release, time the acknowledge
  task automatic reset_pulse(output int ack_cyc);
    int n;
    drive_low <= 1'b1;
    hold(RESET_LOW_MIN_US + 10);
    drive_low <= 1'b0;
    @(posedge clk_sys);
    n = 1;
    while (dq_line === 1'b1 && n < ACK_DELAY_MAX_US * US_DIV + 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    ack_cyc = n;
    hold(ACK_LEN_US + 80);
  endtask : reset_pulse

  // one slot: short low for one, full-slot low for zero
  task automatic write_bit(input logic b);
    int lo;
    lo = b ? 2 : SLOT_MIN_US;
    drive_low <= 1'b1;
    hold(lo);
    drive_low <= 1'b0;
    hold(SLOT_MIN_US + RECOVERY_MIN_US + 1 - lo);
  endtask : write_bit

  task automatic write_byte(input logic [7:0] v);
    int i;
    for (i = 0; i < 8; i++)
      write_bit(v[i]);
  endtask : write_byte

  // read slot: brief low, release, sample at the valid point
  task automatic read_bit(output logic b);
    drive_low <= 1'b1;
    hold(2);
    drive_low <= 1'b0;
    hold(RD_VALID_US - 2);
    b = dq_line;
    hold(SLOT_MIN_US + RECOVERY_MIN_US + 1 - RD_VALID_US);
  endtask : read_bit

  task automatic read_byte(output logic [7:0] v);
    int i;
    for (i = 0; i < 8; i++)
      read_bit(v[i]);
  endtask : read_byte
endmodule : line_master

// ---- tb/single_wire_temperature_link_test.sv ----
`timescale 1ns/1ps
module single_wire_temperature_link_test;
  import thermo_link_pkg::*;

  logic        clk_sys;
  logic        sys_rst;
  logic        dq_o;
  logic        dq_oe;
  logic        drive_low;
  logic        dq_line;
  logic [11:0] sample_data;
  logic        sample_valid;
  logic        sample_ready;
  logic        conv_busy;
  logic [15:0] temp_word;
  int          failures;
  int          n_checks;

  // scaled microsecond keeps the run short
  localparam int US_DIV = 5;
  localparam int ACK_LO = ACK_DELAY_MIN_US * US_DIV;
  localparam int ACK_HI = ACK_DELAY_MAX_US * US_DIV;

  // pull-up line: low while any party pulls it
  assign dq_line = !(drive_low || (dq_oe && !dq_o));

  temp_link_slave #(
    .CONV_US (50),
    .US_DIV  (US_DIV)
  ) temp_link_slave_inst (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .dq_i         (dq_line),
    .dq_o         (dq_o),
    .dq_oe        (dq_oe),
    .sample_data  (sample_data),
    .sample_valid (sample_valid),
    .sample_ready (sample_ready),
    .conv_busy    (conv_busy),
    .temp_word    (temp_word)
  );

  line_master #(
    .US_DIV (US_DIV)
  ) line_master_inst (
    .clk_sys   (clk_sys),
    .dq_line   (dq_line),
    .drive_low (drive_low)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // reporting
  // --------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_idle();
    logic bad;
    bad = 1'b0;
    chk(temp_word === {SIGN_POS, TLO_RST} && conv_busy === 1'b0,
        "reset values");
    repeat (100 * US_DIV)
    begin
      @(posedge clk_sys);
      bad = bad | (dq_oe !== 1'b0);
    end
    chk(!bad, "slave drove an idle line");
    $display("test idle done");
  endtask : t_idle

  task automatic t_fifo();
    int i;
    for (i = 0; i < 8; i++)
    begin
      sample_data  <= (i == 0) ? 12'hFFD : 12'h12C;
      sample_valid <= 1'b1;
      @(posedge clk_sys);
    end
    sample_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(sample_ready === 1'b0, "full buffer still ready");
    @(posedge clk_sys);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_reset();
    int n;
    line_master_inst.reset_pulse(n);
    chk(n >= ACK_LO && n <= ACK_HI, "ack delay");
    chk(n < ACK_HI + 100, "no ack pulse");
    chk(dq_line === 1'b1, "line held after ack");
    $display("test reset done");
  endtask : t_reset

  task automatic t_convert();
    logic b;
    t_reset();
    line_master_inst.write_byte(CMD_SKIP);
    line_master_inst.write_byte(CMD_CONVERT);
    chk(conv_busy === 1'b0, "conversion not finished");
    chk(temp_word === 16'hFFFD, "negative word");
    chk(sample_ready === 1'b1, "oldest sample not taken");
    line_master_inst.read_bit(b);
    chk(b === 1'b1, "done slot not one");
    $display("test convert done");
  endtask : t_convert

  task automatic t_read();
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    t_reset();
    line_master_inst.write_byte(CMD_SKIP);
    line_master_inst.write_byte(CMD_READ_SP);
    line_master_inst.read_byte(b0);
    line_master_inst.read_byte(b1);
    line_master_inst.read_byte(b2);
    chk(b0 === 8'hFD, "low byte first");
    chk(b1 === 8'hFF, "sign byte");
    chk(b2 === NV_UA_RST, "user byte");
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    t_reset();
    line_master_inst.write_byte(CMD_SKIP);
    line_master_inst.write_byte(CMD_WRITE_SP);
    line_master_inst.write_byte(8'h5A);
    line_master_inst.write_byte(8'hC3);
    t_reset();
    line_master_inst.write_byte(CMD_SKIP);
    line_master_inst.write_byte(CMD_READ_SP);
    line_master_inst.read_byte(b0);
    line_master_inst.read_byte(b1);
    line_master_inst.read_byte(b2);
    line_master_inst.read_byte(b3);
    chk(b0 === 8'hFD && b1 === SIGN_NEG, "word kept");
    chk(b2 === 8'h5A, "user byte a written");
    chk(b3 === 8'hC3, "user byte b written");
    $display("test write done");
  endtask : t_write

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    failures     = 0;
    n_checks     = 0;
    sys_rst      = 1'b1;
    sample_data  = 12'h000;
    sample_valid = 1'b0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_idle();
    t_fifo();
    t_convert();
    t_read();
    t_write();
    stop_test();
  end

  initial
  begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule : single_wire_temperature_link_test
